/* lcdcd_top.sv */
// Summary of operation
// - byte with select low is a command, with select high is display data
// - upper nibble 0000 loads low column nibble; column clears at power-on
// - upper nibble 0001 loads high column nibble of 8-bit column
// - prefix 00100 stores 3-bit feedback resistor ratio, reset value 100b
// - prefix 00101 sets buffer, regulator and booster enables, all off at reset
// - top bits 01 load six-bit display start line, reset zero
// - byte 81h then second byte low six bits set contrast, reset 20h, soft reset 00h
// - segment remap bit: zero column 00h first, one column 83h first
// - bias bit: zero one-ninth (reset), one one-seventh
// - entire-display-on override bit, off at reset
// - reverse display bit, normal at reset
// - display on/off bit, off at reset
// - upper nibble 1011 loads page address, valid 0 to 8
// - upper nibble 1100, bit 3 reverses common scan order
// - E0h enters read-modify-write; data reads then keep the column
// - EEh leaves read-modify-write and restores the saved column
// - E2h soft reset reinitialises column, page, start line, contrast, com scan, indicator and test mode and starts initialisation
// - indicator bit; one means next byte is an indicator mode byte
// - mode byte low bits: off, slow blink, fast blink, steady on
// - E3h is a no-operation
// - status read returns busy, segmap, display off, init, id code
// - reset pin pulse of 1us or power-on reset sets default state
// - display off while entire-on is set enters power save
module lcdcd_top #(
  parameter logic [3:0] ID_CODE = 4'h5 // arbitrary identification value
) (
  input wire logic clk_sys, // system clock, 20 MHz
  input wire logic rst_n, // power-on reset, active low
  input wire logic external_reset_n_pin, // reset pin, active low
  input wire logic hostWrite, // parallel write strobe, one cycle
  input wire logic hostRead, // parallel read strobe, one cycle
  input wire logic dataCmdSel, // high data, low command
  input wire logic [7:0] hostDataIn, // parallel write byte
  input wire logic serialSelect_n, // serial port select, active low
  input wire logic serialClk, // serial clock, sampled
  input wire logic serialData, // serial data, msb first
  input wire logic [7:0] ramReadData, // display ram word at column
  output logic [7:0] hostDataOut, // read answer byte
  output logic hostReadValid, // answer valid pulse
  output logic ramWrite, // display data write pulse
  output logic ramRead, // display data read pulse
  output logic [7:0] ramWriteData, // display data byte
  output logic [7:0] columnAddr, // column pointer
  output logic [3:0] pageAddr, // page pointer
  output logic [5:0] startLine, // display start line
  output logic [5:0] contrast, // contrast level
  output logic [2:0] resistorRatio, // regulator feedback ratio
  output logic [2:0] powerEnable, // booster, regulator, buffer
  output logic segRemap, // one: column 83h on first segment
  output logic biasSeventh, // one: one-seventh bias
  output logic entireOn, // all pixels forced on
  output logic reverseDisplay, // pixel polarity inverted
  output logic displayOn, // panel on
  output logic comReverse, // common scan reversed
  output logic rmwActive, // read-modify-write mode
  output logic [1:0] indicatorMode, // static indicator mode
  output logic powerSave, // power save mode
  output logic testMode, // factory test mode latched
  output logic initBusy // initialisation in progress
);
  import lcdcd_pkg::*;

  // column pointer saturates: it must not wrap to zero on overflow
  function automatic logic [7:0] colStep(input logic [7:0] c);
    colStep = (c == COLUMN_LAST) ? c : c + 8'h01;
  endfunction : colStep

  lcdcd_dec_if dec ();
  lcdcd_cmd_parse u_parse (.dec(dec));

  // reset pin filter: a pulse shorter than the minimum is ignored
  logic [5:0] pinLowCount;
  logic pinReset;
  wire pinLowDone = (pinLowCount == 6'(RESET_PULSE_CYC));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinLowCount <= 6'h00;
    end else if (external_reset_n_pin) begin
      pinLowCount <= 6'h00;
    end else if (!pinLowDone) begin
      pinLowCount <= pinLowCount + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinReset <= 1'b0;
    end else begin
      pinReset <= pinLowDone;
    end
  end

  // serial receiver; clock is sampled, so it must be well below clk_sys
  logic sclkLast;
  logic [6:0] shiftReg;
  logic [2:0] bitCount;
  wire sclkRise = serialClk & ~sclkLast & ~serialSelect_n;
  wire serialDone = sclkRise & (bitCount == 3'h7);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclkLast <= 1'b0;
    end else begin
      sclkLast <= serialClk;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= 7'h00;
      bitCount <= 3'h0;
    end else if (pinReset || serialSelect_n) begin
      shiftReg <= 7'h00;
      bitCount <= 3'h0;
    end else if (sclkRise) begin
      shiftReg <= {shiftReg[5:0], serialData};
      bitCount <= bitCount + 3'h1;
    end
  end

  // both ports feed one byte path; select is sampled with the last bit
  wire byteIn = hostWrite | serialDone;
  wire [7:0] byteValue = serialDone ? {shiftReg, serialData} : hostDataIn;
  wire cmdIn = byteIn & ~dataCmdSel;
  wire dataIn = byteIn & dataCmdSel;
  wire statusRead = hostRead & ~dataCmdSel;
  wire dataRead = hostRead & dataCmdSel;

  assign dec.cmdByte = byteValue;

  lcdcd_state_e state;
  lcdcd_state_e next_state;

  wire plainCmd = cmdIn && (state == LCDCD_IDLE);
  wire isCmd = plainCmd && (dec.cmdKind != LCDCD_UNKNOWN);
  wire softReset = plainCmd && (dec.cmdKind == LCDCD_SOFT_RESET);
  wire contrastByte = cmdIn && (state == LCDCD_WAIT_CONTRAST);
  wire modeByte = cmdIn && (state == LCDCD_WAIT_INDICATOR);
  wire arg0 = byteValue[0];

  // second bytes of compound commands bypass the decoder
  always_comb begin
    next_state = state;
    case (state)
      LCDCD_IDLE: begin
        if (isCmd && dec.cmdKind == LCDCD_CONTRAST) begin
          next_state = LCDCD_WAIT_CONTRAST;
        end else if (isCmd && dec.cmdKind == LCDCD_INDICATOR && arg0) begin
          next_state = LCDCD_WAIT_INDICATOR;
        end
      end
      LCDCD_WAIT_CONTRAST: begin
        if (cmdIn) begin
          next_state = LCDCD_IDLE;
        end
      end
      LCDCD_WAIT_INDICATOR: begin
        if (cmdIn) begin
          next_state = LCDCD_IDLE;
        end
      end
      default: begin
        next_state = LCDCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= LCDCD_IDLE;
    end else if (pinReset) begin
      state <= LCDCD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // column pointer and read-modify-write save slot
  logic [7:0] savedColumn;
  wire cmdLowCol = isCmd && dec.cmdKind == LCDCD_LOW_COL;
  wire cmdHighCol = isCmd && dec.cmdKind == LCDCD_HIGH_COL;
  wire cmdRmwIn = isCmd && dec.cmdKind == LCDCD_RMW_ENTER;
  wire cmdRmwOut = isCmd && dec.cmdKind == LCDCD_RMW_EXIT;
  wire dataStep = dataIn | (dataRead & ~rmwActive);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      columnAddr <= COLUMN_RESET;
    end else if (pinReset || softReset) begin
      columnAddr <= COLUMN_RESET;
    end else if (cmdLowCol) begin
      columnAddr <= {columnAddr[7:4], byteValue[3:0]};
    end else if (cmdHighCol) begin
      columnAddr <= {byteValue[3:0], columnAddr[3:0]};
    end else if (cmdRmwOut && rmwActive) begin
      columnAddr <= savedColumn;
    end else if (dataStep) begin
      columnAddr <= colStep(columnAddr);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      savedColumn <= COLUMN_RESET;
      rmwActive <= 1'b0;
    end else if (pinReset) begin
      savedColumn <= COLUMN_RESET;
      rmwActive <= 1'b0;
    end else if (cmdRmwIn) begin
      savedColumn <= columnAddr;
      rmwActive <= 1'b1;
    end else if (cmdRmwOut) begin
      rmwActive <= 1'b0;
    end
  end

  // state that soft reset also clears
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pageAddr <= PAGE_RESET;
      startLine <= START_LINE_RESET;
      contrast <= CONTRAST_RESET;
      comReverse <= 1'b0;
      indicatorMode <= IND_OFF;
      testMode <= 1'b0;
    end else if (pinReset) begin
      pageAddr <= PAGE_RESET;
      startLine <= START_LINE_RESET;
      contrast <= CONTRAST_RESET;
      comReverse <= 1'b0;
      indicatorMode <= IND_OFF;
      testMode <= 1'b0;
    end else if (softReset) begin
      pageAddr <= PAGE_RESET;
      startLine <= START_LINE_RESET;
      contrast <= CONTRAST_SOFT_RESET;
      comReverse <= 1'b0;
      indicatorMode <= IND_OFF;
      testMode <= 1'b0;
    end else if (contrastByte) begin
      contrast <= byteValue[5:0];
    end else if (modeByte) begin
      indicatorMode <= byteValue[1:0];
    end else if (isCmd) begin
      case (dec.cmdKind)
        LCDCD_PAGE: pageAddr <= byteValue[3:0];
        LCDCD_START: startLine <= byteValue[5:0];
        LCDCD_COMSCAN: comReverse <= byteValue[3];
        LCDCD_INDICATOR: begin
          // on waits for the mode byte; off needs none
          if (!arg0) begin
            indicatorMode <= IND_OFF;
          end
        end
        LCDCD_TEST_SET: testMode <= 1'b1;
        LCDCD_TEST_CLEAR: testMode <= 1'b0;
        default: begin
        end
      endcase
    end
  end

  // state that only a hardware reset clears
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resistorRatio <= RATIO_RESET;
      powerEnable <= POWER_RESET;
      segRemap <= 1'b0;
      biasSeventh <= 1'b0;
      entireOn <= 1'b0;
      reverseDisplay <= 1'b0;
      displayOn <= 1'b0;
    end else if (pinReset) begin
      resistorRatio <= RATIO_RESET;
      powerEnable <= POWER_RESET;
      segRemap <= 1'b0;
      biasSeventh <= 1'b0;
      entireOn <= 1'b0;
      reverseDisplay <= 1'b0;
      displayOn <= 1'b0;
    end else if (isCmd) begin
      case (dec.cmdKind)
        LCDCD_RATIO: resistorRatio <= byteValue[2:0];
        LCDCD_POWER: powerEnable <= byteValue[2:0];
        LCDCD_SEGMAP: segRemap <= arg0;
        LCDCD_BIAS: biasSeventh <= arg0;
        LCDCD_ENTIRE: entireOn <= arg0;
        LCDCD_REVERSE: reverseDisplay <= arg0;
        LCDCD_DISPLAY: displayOn <= arg0;
        default: begin
        end
      endcase
    end
  end

  // power save is the compound of entire-on and display off
  wire cmdDisplay = isCmd && dec.cmdKind == LCDCD_DISPLAY;
  wire cmdEntire = isCmd && dec.cmdKind == LCDCD_ENTIRE;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      powerSave <= 1'b0;
    end else if (pinReset) begin
      powerSave <= 1'b0;
    end else if (cmdDisplay) begin
      powerSave <= ~arg0 & entireOn;
    end else if (cmdEntire && !arg0) begin
      powerSave <= 1'b0;
    end
  end

  // initialisation timer after either reset
  logic [7:0] initCount;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      initCount <= 8'(INIT_CYC);
      initBusy <= 1'b1;
    end else if (pinReset || softReset) begin
      initCount <= 8'(INIT_CYC);
      initBusy <= 1'b1;
    end else if (initCount != 8'h00) begin
      initCount <= initCount - 8'h01;
      initBusy <= (initCount != 8'h01);
    end else begin
      initBusy <= 1'b0;
    end
  end

  // status byte; busy reflects the running initialisation
  wire [7:0] statusByte;
  assign statusByte[STAT_BUSY_BIT] = initBusy;
  assign statusByte[STAT_SEGMAP_BIT] = ~segRemap;
  assign statusByte[STAT_OFF_BIT] = ~displayOn;
  assign statusByte[STAT_INIT_BIT] = initBusy;
  assign statusByte[3:0] = ID_CODE;

  // answers and ram strobes are registered one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hostDataOut <= 8'h00;
      hostReadValid <= 1'b0;
      ramWrite <= 1'b0;
      ramRead <= 1'b0;
      ramWriteData <= 8'h00;
    end else begin
      hostReadValid <= hostRead;
      ramWrite <= dataIn;
      ramRead <= dataRead;
      if (dataIn) begin
        ramWriteData <= byteValue;
      end
      if (statusRead) begin
        hostDataOut <= statusByte;
      end else if (dataRead) begin
        hostDataOut <= ramReadData;
      end
    end
  end
endmodule : lcdcd_top

/* lcdcd_pkg.sv */
package lcdcd_pkg;
  // clock and timing
  localparam int CLK_KHZ = 20000;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYC = (INIT_TIME_NS * CLK_KHZ + 999999) / 1000000;

  // power-on and pin reset values, soft reset contrast, last column
  localparam logic [7:0] COLUMN_RESET = 8'h00;
  localparam logic [3:0] PAGE_RESET = 4'h0;
  localparam logic [5:0] START_LINE_RESET = 6'h00;
  localparam logic [5:0] CONTRAST_RESET = 6'h20;
  localparam logic [5:0] CONTRAST_SOFT_RESET = 6'h00;
  localparam logic [2:0] RATIO_RESET = 3'h4;
  localparam logic [2:0] POWER_RESET = 3'h0;
  localparam logic [7:0] COLUMN_LAST = 8'hff;

  // power enable bit positions
  localparam int PWR_BUFFER_BIT = 0;
  localparam int PWR_REGULATOR_BIT = 1;
  localparam int PWR_BOOSTER_BIT = 2;

  // status byte bit positions
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_SEGMAP_BIT = 6;
  localparam int STAT_OFF_BIT = 5;
  localparam int STAT_INIT_BIT = 4;

  // indicator modes
  localparam logic [1:0] IND_OFF = 2'h0;
  localparam logic [1:0] IND_BLINK_SLOW = 2'h1;
  localparam logic [1:0] IND_BLINK_FAST = 2'h2;
  localparam logic [1:0] IND_STEADY = 2'h3;

  typedef enum {
    LCDCD_LOW_COL, LCDCD_HIGH_COL, LCDCD_RATIO, LCDCD_POWER, LCDCD_START,
    LCDCD_CONTRAST, LCDCD_SEGMAP, LCDCD_BIAS, LCDCD_ENTIRE, LCDCD_REVERSE,
    LCDCD_DISPLAY, LCDCD_PAGE, LCDCD_COMSCAN, LCDCD_RMW_ENTER,
    LCDCD_RMW_EXIT, LCDCD_SOFT_RESET, LCDCD_INDICATOR, LCDCD_NOP,
    LCDCD_TEST_CLEAR, LCDCD_TEST_SET, LCDCD_UNKNOWN
  } lcdcd_cmd_e;

  typedef enum {LCDCD_IDLE, LCDCD_WAIT_CONTRAST, LCDCD_WAIT_INDICATOR}
    lcdcd_state_e;
endpackage : lcdcd_pkg

/* lcdcd_dec_if.sv */
interface lcdcd_dec_if;
  import lcdcd_pkg::*;
  logic [7:0] cmdByte;
  lcdcd_cmd_e cmdKind;
  modport parser (input cmdByte, output cmdKind);
  modport user (output cmdByte, input cmdKind);
endinterface : lcdcd_dec_if

/* lcdcd_cmd_parse.sv */
module lcdcd_cmd_parse (
  lcdcd_dec_if.parser dec // byte in, command kind out
);
  import lcdcd_pkg::*;

  wire [7:0] b = dec.cmdByte;

  // longest prefixes are tested first so the full-byte commands win
  always_comb begin
    if (b == 8'h81) begin
      dec.cmdKind = LCDCD_CONTRAST;
    end else if (b == 8'he0) begin
      dec.cmdKind = LCDCD_RMW_ENTER;
    end else if (b == 8'hee) begin
      dec.cmdKind = LCDCD_RMW_EXIT;
    end else if (b == 8'he2) begin
      dec.cmdKind = LCDCD_SOFT_RESET;
    end else if (b == 8'he3) begin
      dec.cmdKind = LCDCD_NOP;
    end else if (b == 8'hf0) begin
      dec.cmdKind = LCDCD_TEST_CLEAR;
    end else if (b[7:1] == 7'h50) begin
      dec.cmdKind = LCDCD_SEGMAP;
    end else if (b[7:1] == 7'h51) begin
      dec.cmdKind = LCDCD_BIAS;
    end else if (b[7:1] == 7'h52) begin
      dec.cmdKind = LCDCD_ENTIRE;
    end else if (b[7:1] == 7'h53) begin
      dec.cmdKind = LCDCD_REVERSE;
    end else if (b[7:1] == 7'h56) begin
      dec.cmdKind = LCDCD_INDICATOR;
    end else if (b[7:1] == 7'h57) begin
      dec.cmdKind = LCDCD_DISPLAY;
    end else if (b[7:3] == 5'h04) begin
      dec.cmdKind = LCDCD_RATIO;
    end else if (b[7:3] == 5'h05) begin
      dec.cmdKind = LCDCD_POWER;
    end else if (b[7:4] == 4'h0) begin
      dec.cmdKind = LCDCD_LOW_COL;
    end else if (b[7:4] == 4'h1) begin
      dec.cmdKind = LCDCD_HIGH_COL;
    end else if (b[7:4] == 4'hb) begin
      dec.cmdKind = LCDCD_PAGE;
    end else if (b[7:4] == 4'hc) begin
      dec.cmdKind = LCDCD_COMSCAN;
    end else if (b[7:4] == 4'hf) begin
      dec.cmdKind = LCDCD_TEST_SET;
    end else if (b[7:6] == 2'h1) begin
      dec.cmdKind = LCDCD_START;
    end else begin
      dec.cmdKind = LCDCD_UNKNOWN;
    end
  end
endmodule : lcdcd_cmd_parse

/* lcdcd_checker_assertions.sv */
module lcdcd_checker #(
  parameter logic [3:0] ID_CODE = 4'h5 // identification nibble
) (
  input wire logic clk_sys, // clock
  input wire logic rst_n, // reset
  input wire logic hostWrite, // write strobe
  input wire logic hostRead, // read strobe
  input wire logic dataCmdSel, // data high
  input wire logic [7:0] hostDataIn, // write byte
  input wire logic [7:0] hostDataOut, // read byte
  input wire logic hostReadValid, // read valid
  input wire logic ramWrite, // ram write
  input wire logic ramRead, // ram read
  input wire logic [7:0] ramWriteData, // ram byte
  input wire logic [7:0] columnAddr, // column
  input wire logic [5:0] startLine, // start line
  input wire logic [5:0] contrast, // contrast
  input wire logic [2:0] resistorRatio, // ratio
  input wire logic [2:0] powerEnable, // power
  input wire logic segRemap, // remap
  input wire logic displayOn, // panel on
  input wire logic rmwActive, // rmw mode
  input wire logic initBusy // init busy
);
  logic pendC;
  logic pendI;
  wire cmdW = hostWrite && !dataCmdSel;
  // second bytes of compound commands must not be decoded as commands
  wire fresh = cmdW && !pendC && !pendI;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pendC <= 1'b0;
      pendI <= 1'b0;
    end else if (cmdW) begin
      pendC <= fresh && hostDataIn == 8'h81;
      pendI <= fresh && hostDataIn == 8'had;
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  col_low_a: assert property (fresh && hostDataIn[7:4] == 4'h0 |=>
    columnAddr[3:0] == $past(hostDataIn[3:0])) else $error("low column");
  col_high_a: assert property (fresh && hostDataIn[7:4] == 4'h1 |=>
    columnAddr[7:4] == $past(hostDataIn[3:0])) else $error("high column");
  ratio_set_a: assert property (fresh && hostDataIn[7:3] == 5'h04 |=>
    resistorRatio == $past(hostDataIn[2:0])) else $error("ratio");
  power_set_a: assert property (fresh && hostDataIn[7:3] == 5'h05 |=>
    powerEnable == $past(hostDataIn[2:0])) else $error("power");
  start_line_a: assert property (fresh && hostDataIn[7:6] == 2'h1 |=>
    startLine == $past(hostDataIn[5:0])) else $error("start line");
  contrast_val_a: assert property (cmdW && pendC |=>
    contrast == $past(hostDataIn[5:0])) else $error("contrast");
  display_set_a: assert property (fresh && hostDataIn[7:1] == 7'h57 |=>
    displayOn == $past(hostDataIn[0])) else $error("display");
  status_byte_a: assert property (hostRead && !dataCmdSel |=>
    hostReadValid && hostDataOut == {$past(initBusy), !$past(segRemap),
    !$past(displayOn), $past(initBusy), ID_CODE}) else $error("status");
  status_keep_a: assert property (hostRead && !dataCmdSel && !hostWrite
    |=> $stable(columnAddr)) else $error("status moved column");
  rmw_read_a: assert property (hostRead && dataCmdSel && rmwActive
    |=> ramRead && $stable(columnAddr)) else $error("rmw read");
  data_write_a: assert property (hostWrite && dataCmdSel &&
    columnAddr != 8'hff |=> ramWrite && ramWriteData == $past(hostDataIn)
    && columnAddr == $past(columnAddr) + 8'h01) else $error("data write");
  soft_reset_a: assert property (fresh && hostDataIn == 8'he2 |=>
    initBusy [*8]) else $error("soft reset busy");
  nop_keep_a: assert property (fresh && hostDataIn == 8'he3 |=>
    $stable({columnAddr, contrast, startLine, powerEnable}))
    else $error("nop changed state");
endmodule : lcdcd_checker

bind lcdcd_top lcdcd_checker #(.ID_CODE(ID_CODE)) lcdcd_checker_inst (
  .clk_sys, .rst_n, .hostWrite, .hostRead, .dataCmdSel, .hostDataIn,
  .hostDataOut, .hostReadValid, .ramWrite, .ramRead, .ramWriteData,
  .columnAddr, .startLine, .contrast, .resistorRatio, .powerEnable,
  .segRemap, .displayOn, .rmwActive, .initBusy);

/* lcdcd_host_model.sv */
module lcdcd_host_model (
  input wire logic clk_sys, // clock
  output logic hostWrite, // write strobe
  output logic hostRead, // read strobe
  output logic dataCmdSel, // data high
  output logic [7:0] hostDataIn, // write byte
  output logic serialSelect_n, // serial select
  output logic serialClk, // serial clock
  output logic serialData, // serial bit
  output logic external_reset_n_pin // reset pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {hostWrite, hostRead, dataCmdSel, serialClk, serialData} = 5'h00;
    {serialSelect_n, external_reset_n_pin} = 2'h3;
    hostDataIn = 8'h00;
  end
  // one strobe per three cycles keeps every answer apart from the next
  task automatic put(input logic rd, input logic dc, input logic [7:0] b);
    @(negedge clk_sys);
    // factory test patterns are never sent
    if (!rd && !dc && b[7:4] == 4'hf) return;
    hostRead = rd;
    hostWrite = !rd;
    dataCmdSel = dc;
    hostDataIn = b;
    @(negedge clk_sys);
    hostRead = 1'b0;
    hostWrite = 1'b0;
    hostDataIn = ~b;
    @(negedge clk_sys);
  endtask : put
  task automatic pin(input int n);
    @(negedge clk_sys);
    external_reset_n_pin = 1'b0;
    repeat (n) @(negedge clk_sys);
    external_reset_n_pin = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask : pin
  task automatic ser(input logic dc, input logic [7:0] b);
    @(negedge clk_sys);
    serialSelect_n = 1'b0;
    dataCmdSel = dc;
    for (int i = 7; i >= 0; i--) begin
      serialData = b[i];
      serialClk = 1'b0;
      @(negedge clk_sys);
      serialClk = 1'b1;
      @(negedge clk_sys);
    end
    serialClk = 1'b0;
    repeat (2) @(negedge clk_sys);
    serialSelect_n = 1'b1;
    serialData = ~serialData;
    @(negedge clk_sys);
  endtask : ser
endmodule : lcdcd_host_model

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ID = 4'h9; // arbitrary identification value
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ramReadData = 8'h00;
  logic hostWrite, hostRead, dataCmdSel, serialSelect_n, serialClk;
  logic serialData, external_reset_n_pin, hostReadValid, ramWrite, ramRead;
  logic segRemap, biasSeventh, entireOn, reverseDisplay, displayOn;
  logic comReverse, rmwActive, powerSave, testMode, initBusy, b;
  logic [7:0] hostDataIn, hostDataOut, ramWriteData, columnAddr, c;
  logic [3:0] pageAddr;
  logic [5:0] startLine, contrast;
  logic [2:0] resistorRatio, powerEnable;
  logic [1:0] indicatorMode;
  logic [8:0] q;
  logic [8:0] expQ[$];
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #25 clk_sys = ~clk_sys;
  lcdcd_top #(.ID_CODE(ID)) lcdcd_top_inst (.clk_sys, .rst_n,
    .external_reset_n_pin, .hostWrite, .hostRead, .dataCmdSel, .hostDataIn,
    .serialSelect_n, .serialClk, .serialData, .ramReadData, .hostDataOut,
    .hostReadValid, .ramWrite, .ramRead, .ramWriteData, .columnAddr,
    .pageAddr, .startLine, .contrast, .resistorRatio, .powerEnable,
    .segRemap, .biasSeventh, .entireOn, .reverseDisplay, .displayOn,
    .comReverse, .rmwActive, .indicatorMode, .powerSave, .testMode,
    .initBusy);
  lcdcd_host_model lcdcd_host_model_inst (.clk_sys, .hostWrite, .hostRead,
    .dataCmdSel, .hostDataIn, .serialSelect_n, .serialClk, .serialData,
    .external_reset_n_pin);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    if (expQ.size() != 0) mismatches++;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic cmd(input logic [7:0] v);
    lcdcd_host_model_inst.put(1'b0, 1'b0, v);
  endtask : cmd
  task automatic dat(input logic [7:0] v);
    expQ.push_back({1'b0, v});
    lcdcd_host_model_inst.put(1'b0, 1'b1, v);
  endtask : dat
  task automatic sts(input logic [7:0] v);
    expQ.push_back({1'b1, v});
    lcdcd_host_model_inst.put(1'b1, 1'b0, 8'h00);
  endtask : sts
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done
  // data reads answer too, so only status notes are matched to valid
  always @(negedge clk_sys) begin
    cycles++;
    ramReadData <= 8'($urandom);
    // ramReadData still holds the word the design sampled on the read edge
    if (ramRead === 1'b1) chk("ramRead", ramReadData, hostDataOut);
    if (ramWrite === 1'b1 || (hostReadValid === 1'b1 && expQ.size() > 0
        && expQ[0][8] === 1'b1)) begin
      if (expQ.size() == 0) chk("ramWrite", 8'h00, 8'h01);
      else begin
        q = expQ.pop_front();
        chk("readback", q[7:0], q[8] ? hostDataOut : ramWriteData);
      end
    end
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h441bd162));
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("contrast", 8'h20, contrast);
    chk("ratio", 8'h04, resistorRatio);
    chk("flags", 8'h00, {powerEnable, displayOn, rmwActive, testMode});
    chk("column", 8'h00, columnAddr | indicatorMode | startLine);
    sts({4'hf, ID});
    done("reset");
    for (int i = 0; i < 2; i++) begin
      b = i[0];
      cmd({7'h50, b});
      cmd({7'h51, b});
      cmd({7'h52, b});
      cmd({7'h53, b});
      cmd({7'h57, b});
      cmd({4'hc, b, 3'h5});
      chk("modes", {2'h0, {6{b}}}, {2'h0, segRemap, biasSeventh, entireOn,
        reverseDisplay, displayOn, comReverse});
      chk("save", 8'h00, powerSave);
      repeat (45) @(negedge clk_sys);
      sts({1'b0, ~b, ~b, 1'b0, ID});
    end
    done("modes");
    repeat (4) begin
      c = 8'($urandom);
      cmd({4'h0, c[3:0]});
      cmd({4'h1, c[7:4]});
      chk("column", c, columnAddr);
      cmd({5'h04, c[2:0]});
      cmd({5'h05, c[6:4]});
      chk("ratio", {2'h0, c[2:0], c[6:4]}, {resistorRatio, powerEnable});
      cmd({2'h1, c[5:0]});
      chk("start", c[5:0], startLine);
      cmd({4'hb, 4'(c % 9)});
      chk("page", 8'(c % 9), pageAddr);
    end
    done("address");
    cmd(8'h81);
    dat(8'h5a);
    cmd(8'he3);
    chk("contrast", 8'h23, contrast);
    for (int m = 0; m < 4; m++) begin
      cmd(8'had);
      cmd({6'h2b, m[1:0]});
      chk("indicator", 8'(m), indicatorMode);
    end
    cmd(8'hac);
    chk("indicator", 8'h00, indicatorMode);
    done("compound");
    cmd(8'h0e);
    cmd(8'h1f);
    dat(c);
    dat(~c);
    chk("column", 8'hff, columnAddr);
    sts({4'h0, ID});
    chk("column", 8'hff, columnAddr);
    cmd(8'h00);
    cmd(8'h11);
    cmd(8'he0);
    lcdcd_host_model_inst.put(1'b1, 1'b1, 8'h00);
    lcdcd_host_model_inst.put(1'b1, 1'b1, 8'h00);
    chk("column", 8'h10, columnAddr);
    dat(c);
    chk("column", 8'h11, columnAddr);
    cmd(8'hee);
    chk("column", 8'h10, columnAddr | rmwActive);
    done("data");
    cmd(8'he3);
    chk("column", 8'h10, columnAddr);
    chk("contrast", 8'h23, contrast);
    lcdcd_host_model_inst.put(1'b1, 1'b1, 8'h00);
    chk("column", 8'h11, columnAddr);
    cmd(8'ha5);
    cmd(8'hae);
    chk("save", 8'h01, powerSave);
    cmd(8'he2);
    chk("soft", 8'h00, columnAddr | startLine | contrast | comReverse);
    chk("kept", c[6:4], powerEnable);
    sts({4'hb, ID});
    done("soft reset");
    lcdcd_host_model_inst.pin(10);
    chk("contrast", 8'h00, contrast);
    lcdcd_host_model_inst.pin(25);
    chk("contrast", 8'h20, contrast);
    chk("power", 8'h00, powerEnable);
    lcdcd_host_model_inst.ser(1'b0, 8'h55);
    chk("start", 8'h15, startLine);
    expQ.push_back({1'b0, 8'h3c});
    lcdcd_host_model_inst.ser(1'b1, 8'h3c);
    chk("column", 8'h01, columnAddr);
    done("pin and serial");
    give_verdict();
  end
endmodule : tb_top
